// *** term_decode_pkg.sv ***
// shared constants and types for the input terminal command decoder
package term_decode_pkg;
	localparam int NUM_GP = 3;
	localparam int NUM_PINS = 5;
	localparam int IDX_FWD_PIN = 3;
	localparam int IDX_REV_PIN = 4;
	localparam logic [10:0] NEG_OFFSET = 11'h3e8;
	localparam logic [10:0] CODE_SS0 = 11'h000;
	localparam logic [10:0] CODE_SS1 = 11'h001;
	localparam logic [10:0] CODE_SS2 = 11'h002;
	localparam logic [10:0] CODE_SS3 = 11'h003;
	localparam logic [10:0] CODE_RAMP = 11'h004;
	localparam logic [10:0] CODE_HOLD = 11'h006;
	localparam logic [10:0] CODE_COAST = 11'h007;
	localparam logic [10:0] CODE_ARST = 11'h008;
	localparam logic [10:0] CODE_TRIP = 11'h009;
	localparam logic [10:0] CODE_JOG = 11'h00a;
	localparam logic [10:0] CODE_FSRC = 11'h00b;
	localparam logic [10:0] CODE_MSEL = 11'h00c;
	localparam logic [10:0] CODE_DC_BRAKE_ENABLE = 11'h00d;
	localparam logic [10:0] CODE_UP = 11'h011;
	localparam logic [10:0] CODE_DOWN = 11'h012;
	localparam logic [10:0] CODE_KEYPAD = 11'h013;
	localparam logic [10:0] CODE_PIDCAN = 11'h014;
	localparam logic [10:0] CODE_INV = 11'h015;
	localparam logic [10:0] CODE_LINK = 11'h018;
	localparam logic [10:0] CODE_PIDCLR = 11'h021;
	localparam logic [10:0] CODE_PIDFRZ = 11'h022;
	localparam logic [10:0] CODE_FWD = 11'h062;
	localparam logic [10:0] CODE_REV = 11'h063;
	localparam logic [10:0] RESET_ASSIGN = 11'h000;
	localparam logic [3:0] SPEED_NONE = 4'h0;

	typedef struct packed {
		logic preset_speed_bit3;
		logic preset_speed_bit2;
		logic preset_speed_bit1;
		logic preset_speed_bit0;
		logic ramp_set_select;
		logic three_wire_latch;
		logic coast_stop_cmd;
		logic alarm_reset;
		logic external_trip_cmd;
		logic jog_ready;
		logic freq_source_select;
		logic motor_select;
		logic dc_brake_enable;
		logic freq_up;
		logic freq_down;
		logic keypad_edit_enable;
		logic pid_cancel_cmd;
		logic inverse_action_select;
		logic serial_link_enable;
		logic pid_state_clear;
		logic pid_integral_freeze;
		logic run_forward;
		logic run_backward;
	} cmd_t;
endpackage

// *** input_terminal_command_decoder.sv ***
// decodes digital input terminals into internal drive commands
// Functional notes
// R1 - assignment code selects one terminal command
// R2 - run codes only on dedicated run pins
// R3 - code plus 1000 gives active-low form; the code decodes no command from 1013, 1098 or 1099
// R4 - external trip polarity inverted for fail-safe
// R5 - four preset bits index stored frequencies
// R6 - all preset bits off passes normal reference
// R7 - ramp select picks first or second pair
// R8 - unassigned ramp select uses first pair
// R9 - hold latches first run edge
// R10 - dropping hold clears latched run
// R11 - no hold assigned gives two-wire run
// R12 - coast stop disables output, no alarm
// R13 - alarm reset deasserts fault alarm
// R14 - reset release clears display and hold
// R15 - external reset pulse at least 10 ms
// R16 - keep reset inactive during normal running
// R17 - separate assignment per terminal
// R18 - assignments reset to active-high
// R19 - two-stage synchroniser on each terminal
// R20 - unassigned inactive, multiple assignments ORed
module input_terminal_command_decoder #(
	parameter int FREQ_W = 16
)(
	input wire logic clk,
	input wire logic rst,
	// terminal pins, asynchronous
	input wire logic [term_decode_pkg::NUM_GP-1:0] gp_terminal,
	input wire logic fwd_terminal,
	input wire logic rev_terminal,
	// terminal assignment codes
	input wire logic [10:0] input1_assignment,
	input wire logic [10:0] input2_assignment,
	input wire logic [10:0] input3_assignment,
	input wire logic [10:0] fwd_pin_assignment,
	input wire logic [10:0] rev_pin_assignment,
	// frequency and ramp settings
	input wire logic [FREQ_W-1:0] primary_freq_source,
	input wire logic [FREQ_W-1:0] secondary_freq_source,
	input wire logic [15*FREQ_W-1:0] preset_frequency_table,
	input wire logic [FREQ_W-1:0] accel_time_first,
	input wire logic [FREQ_W-1:0] decel_time_first,
	input wire logic [FREQ_W-1:0] accel_time_second,
	input wire logic [FREQ_W-1:0] decel_time_second,
	// fault from the protection logic
	input wire logic fault_event,
	// decoded results
	output term_decode_pkg::cmd_t cmd_reg,
	output logic [3:0] speed_index_reg,
	output logic [FREQ_W-1:0] freq_ref_reg,
	output logic [FREQ_W-1:0] accel_time_reg,
	output logic [FREQ_W-1:0] decel_time_reg,
	output logic run_fwd_reg,
	output logic run_rev_reg,
	output logic drive_enable_reg,
	output logic fault_alarm_output,
	output logic alarm_display_reg,
	output logic trip_hold_reg
);
	localparam int N = term_decode_pkg::NUM_PINS;

	logic [N-1:0] sync1_reg;
	logic [N-1:0] sync2_reg;
	logic [N-1:0][10:0] assign_reg;
	logic [N-1:0] level_reg;
	logic [N-1:0] is_neg;
	logic [N-1:0][10:0] base;
	logic [N-1:0] act;
	term_decode_pkg::cmd_t cmd_next;
	logic hold_assigned;
	logic hold_prev_reg;
	logic arst_prev_reg;
	logic fwd_prev_reg;
	logic rev_prev_reg;

	// [R19] three flip-flops (two sync stages plus level_reg) before any decode
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= {rev_terminal, fwd_terminal, gp_terminal};
			sync2_reg <= sync1_reg;
		end
	end

	// [R17] per terminal assignment, [R18] reset to active-high code
	always_ff @(posedge clk)
	begin
		if (rst)
			assign_reg <= {N{term_decode_pkg::RESET_ASSIGN}};
		else
			assign_reg <= {rev_pin_assignment, fwd_pin_assignment,
				input3_assignment, input2_assignment, input1_assignment};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			level_reg <= '0;
		else
			level_reg <= sync2_reg;
	end

	// polarity correction per terminal
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_pol
			assign is_neg[g] = assign_reg[g] >= term_decode_pkg::NEG_OFFSET; // [R3]
			assign base[g] = is_neg[g] ? 11'(assign_reg[g] - term_decode_pkg::NEG_OFFSET)
				: assign_reg[g];
			// [R4] trip code is active when the corrected level is low
			assign act[g] = ((base[g] == term_decode_pkg::CODE_TRIP) ^ is_neg[g]) ?
				~level_reg[g] : level_reg[g];
		end
	endgenerate

	// [R1] [R20] each command is the OR of the terminals carrying its code, less those barred by [R2] and [R3]
	function automatic logic hit(input logic [10:0] code, input logic allow_neg,
		input logic run_only);
		logic r;
		r = 1'b0;
		for (int i = 0; i < N; i++)
		begin
			// [R2] run codes only from the dedicated run pins
			if (base[i] == code && (allow_neg || !is_neg[i])
				&& (!run_only || i >= term_decode_pkg::IDX_FWD_PIN))
				r = r | act[i];
		end
		return r;
	endfunction

	always_comb
	begin
		cmd_next.preset_speed_bit0 = hit(term_decode_pkg::CODE_SS0, 1'b1, 1'b0);
		cmd_next.preset_speed_bit1 = hit(term_decode_pkg::CODE_SS1, 1'b1, 1'b0);
		cmd_next.preset_speed_bit2 = hit(term_decode_pkg::CODE_SS2, 1'b1, 1'b0);
		cmd_next.preset_speed_bit3 = hit(term_decode_pkg::CODE_SS3, 1'b1, 1'b0);
		cmd_next.ramp_set_select = hit(term_decode_pkg::CODE_RAMP, 1'b1, 1'b0);
		cmd_next.three_wire_latch = hit(term_decode_pkg::CODE_HOLD, 1'b1, 1'b0);
		cmd_next.coast_stop_cmd = hit(term_decode_pkg::CODE_COAST, 1'b1, 1'b0);
		cmd_next.alarm_reset = hit(term_decode_pkg::CODE_ARST, 1'b1, 1'b0);
		cmd_next.external_trip_cmd = hit(term_decode_pkg::CODE_TRIP, 1'b1, 1'b0);
		cmd_next.jog_ready = hit(term_decode_pkg::CODE_JOG, 1'b1, 1'b0);
		cmd_next.freq_source_select = hit(term_decode_pkg::CODE_FSRC, 1'b1, 1'b0);
		cmd_next.motor_select = hit(term_decode_pkg::CODE_MSEL, 1'b1, 1'b0);
		cmd_next.dc_brake_enable = hit(term_decode_pkg::CODE_DC_BRAKE_ENABLE, 1'b0, 1'b0); // [R3]
		cmd_next.freq_up = hit(term_decode_pkg::CODE_UP, 1'b1, 1'b0);
		cmd_next.freq_down = hit(term_decode_pkg::CODE_DOWN, 1'b1, 1'b0);
		cmd_next.keypad_edit_enable = hit(term_decode_pkg::CODE_KEYPAD, 1'b1, 1'b0);
		cmd_next.pid_cancel_cmd = hit(term_decode_pkg::CODE_PIDCAN, 1'b1, 1'b0);
		cmd_next.inverse_action_select = hit(term_decode_pkg::CODE_INV, 1'b1, 1'b0);
		cmd_next.serial_link_enable = hit(term_decode_pkg::CODE_LINK, 1'b1, 1'b0);
		cmd_next.pid_state_clear = hit(term_decode_pkg::CODE_PIDCLR, 1'b1, 1'b0);
		cmd_next.pid_integral_freeze = hit(term_decode_pkg::CODE_PIDFRZ, 1'b1, 1'b0);
		cmd_next.run_forward = hit(term_decode_pkg::CODE_FWD, 1'b0, 1'b1); // [R2] [R3]
		cmd_next.run_backward = hit(term_decode_pkg::CODE_REV, 1'b0, 1'b1);
		hold_assigned = 1'b0;
		for (int i = 0; i < N; i++)
			hold_assigned = hold_assigned | (base[i] == term_decode_pkg::CODE_HOLD);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cmd_reg <= '0;
		else
			cmd_reg <= cmd_next;
	end

	// [R5] [R6] preset index and frequency reference
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			speed_index_reg <= term_decode_pkg::SPEED_NONE;
			freq_ref_reg <= '0;
		end
		else
		begin
			speed_index_reg <= {cmd_next.preset_speed_bit3, cmd_next.preset_speed_bit2,
				cmd_next.preset_speed_bit1, cmd_next.preset_speed_bit0};
			if (speed_index_reg == term_decode_pkg::SPEED_NONE)
				freq_ref_reg <= cmd_reg.freq_source_select ? secondary_freq_source
					: primary_freq_source;
			else
				freq_ref_reg <= preset_frequency_table[
					(32'(speed_index_reg) - 1) * FREQ_W +: FREQ_W];
		end
	end

	// [R7] [R8] unassigned select reads low, so first pair is default
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			accel_time_reg <= '0;
			decel_time_reg <= '0;
		end
		else
		begin
			accel_time_reg <= cmd_next.ramp_set_select ? accel_time_second : accel_time_first;
			decel_time_reg <= cmd_next.ramp_set_select ? decel_time_second : decel_time_first;
		end
	end

	// run control: three-wire self hold or two-wire level
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			run_fwd_reg <= 1'b0;
			run_rev_reg <= 1'b0;
			fwd_prev_reg <= 1'b0;
			rev_prev_reg <= 1'b0;
			hold_prev_reg <= 1'b0;
		end
		else
		begin
			fwd_prev_reg <= cmd_next.run_forward;
			rev_prev_reg <= cmd_next.run_backward;
			hold_prev_reg <= cmd_next.three_wire_latch;
			if (!hold_assigned)
			begin
				run_fwd_reg <= cmd_next.run_forward; // [R11]
				run_rev_reg <= cmd_next.run_backward;
			end
			else if (!cmd_next.three_wire_latch)
			begin
				run_fwd_reg <= 1'b0; // [R10]
				run_rev_reg <= 1'b0;
			end
			else if (!run_fwd_reg && !run_rev_reg)
			begin
				// first rising run edge wins; forward if both at once [R9]
				if (cmd_next.run_forward && !fwd_prev_reg)
					run_fwd_reg <= 1'b1;
				else if (cmd_next.run_backward && !rev_prev_reg)
					run_rev_reg <= 1'b1;
			end
		end
	end

	// [R12] coast stop kills output immediately, alarm untouched
	always_ff @(posedge clk)
	begin
		if (rst)
			drive_enable_reg <= 1'b0;
		else
			drive_enable_reg <= !cmd_next.coast_stop_cmd && !trip_hold_reg
				&& (run_fwd_reg || run_rev_reg);
	end

	// alarm: trip self-holds; reset drops relay on press, clears hold on release
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fault_alarm_output <= 1'b0;
			alarm_display_reg <= 1'b0;
			trip_hold_reg <= 1'b0;
			arst_prev_reg <= 1'b0;
		end
		else
		begin
			arst_prev_reg <= cmd_next.alarm_reset;
			// new faults set over any clear in the same cycle
			if (cmd_next.external_trip_cmd || fault_event)
			begin
				fault_alarm_output <= 1'b1;
				alarm_display_reg <= 1'b1;
				trip_hold_reg <= 1'b1;
			end
			else
			begin
				if (cmd_next.alarm_reset)
					fault_alarm_output <= 1'b0; // [R13]
				if (arst_prev_reg && !cmd_next.alarm_reset)
				begin
					alarm_display_reg <= 1'b0; // [R14]
					trip_hold_reg <= 1'b0;
				end
			end
		end
	end
endmodule

// *** term_decode_properties.sv ***
// port assertions for the terminal command decoder
module term_decode_properties #(
	parameter int FREQ_W = 16
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// inputs
	input wire logic [15*FREQ_W-1:0] preset_frequency_table,
	input wire logic [FREQ_W-1:0] accel_time_second,
	input wire logic fault_event,
	// results
	input wire term_decode_pkg::cmd_t cmd_reg,
	input wire logic [3:0] speed_index_reg,
	input wire logic [FREQ_W-1:0] freq_ref_reg,
	input wire logic [FREQ_W-1:0] accel_time_reg,
	input wire logic run_fwd_reg,
	input wire logic run_rev_reg,
	input wire logic drive_enable_reg,
	input wire logic fault_alarm_output,
	input wire logic alarm_display_reg,
	input wire logic trip_hold_reg
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_coast;
		cmd_reg.coast_stop_cmd && !cmd_reg.external_trip_cmd && !$past(fault_event)
			&& !$past(fault_alarm_output) |-> !drive_enable_reg && !fault_alarm_output;
	endproperty
	a_coast: assert property (p_coast) else $error("drive on during coast");
	property p_trip;
		cmd_reg.external_trip_cmd |-> ##[0:1] fault_alarm_output;
	endproperty
	a_trip: assert property (p_trip) else $error("trip without alarm");
	property p_press;
		$rose(cmd_reg.alarm_reset) && !cmd_reg.external_trip_cmd && !fault_event
			|-> ##[0:1] !fault_alarm_output;
	endproperty
	a_press: assert property (p_press) else $error("alarm kept on reset");
	property p_release;
		$fell(cmd_reg.alarm_reset) && !cmd_reg.external_trip_cmd && !fault_event
			|-> ##[0:1] !alarm_display_reg && !trip_hold_reg;
	endproperty
	a_release: assert property (p_release) else $error("display kept");
	property p_hold_drop;
		$fell(cmd_reg.three_wire_latch) |-> ##[0:1] !run_fwd_reg && !run_rev_reg;
	endproperty
	a_hold_drop: assert property (p_hold_drop) else $error("run kept");
	property p_hold_keep;
		cmd_reg.three_wire_latch && $past(cmd_reg.three_wire_latch) && $past(run_fwd_reg)
			|-> run_fwd_reg;
	endproperty
	a_hold_keep: assert property (p_hold_keep) else $error("run lost");
	property p_ramp;
		cmd_reg.ramp_set_select && $stable(accel_time_second)
			|-> accel_time_reg == accel_time_second;
	endproperty
	a_ramp: assert property (p_ramp) else $error("wrong ramp pair");
	property p_preset;
		speed_index_reg != 4'h0 && $past(speed_index_reg) == speed_index_reg
			&& $past(speed_index_reg, 2) == speed_index_reg
			|-> freq_ref_reg == preset_frequency_table[(speed_index_reg - 4'h1) * FREQ_W +: FREQ_W];
	endproperty
	a_preset: assert property (p_preset) else $error("wrong preset");
endmodule

// *** term_driver.sv ***
// external switch model driving the terminals
module term_driver (
	input wire logic clk,
	input wire logic slow,
	// wanted levels {rev, fwd, gp2, gp1, gp0}
	input wire logic [4:0] want,
	output logic [2:0] gp_terminal,
	output logic fwd_terminal,
	output logic rev_terminal
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] lag_reg = 5'h00;
	// slow relays settle one cycle late, just after the edge
	always @(posedge clk)
		lag_reg <= #1 want;
	assign {rev_terminal, fwd_terminal, gp_terminal} = slow ? lag_reg : want;
endmodule

// *** input_terminal_command_decoder_test.sv ***
// self-checking bench for the terminal command decoder
module input_terminal_command_decoder_test;
	timeunit 1ns;
	// finer precision keeps the 12.5 ns half period exact
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, slow = 1'b0, fault_event = 1'b0;
	logic [4:0] want = 5'h00;
	logic [2:0] gp_terminal;
	logic fwd_terminal, rev_terminal;
	logic [10:0] input1_assignment, input2_assignment, input3_assignment;
	logic [10:0] fwd_pin_assignment, rev_pin_assignment;
	logic [15:0] primary_freq_source = 16'h0aaa, secondary_freq_source = 16'h0bbb;
	logic [239:0] preset_frequency_table;
	logic [15:0] accel_time_first = 16'h0011, decel_time_first = 16'h0022;
	logic [15:0] accel_time_second = 16'h0033, decel_time_second = 16'h0044;
	term_decode_pkg::cmd_t cmd_reg;
	logic [3:0] speed_index_reg;
	logic [15:0] freq_ref_reg, accel_time_reg, decel_time_reg;
	logic run_fwd_reg, run_rev_reg, drive_enable_reg;
	logic fault_alarm_output, alarm_display_reg, trip_hold_reg;
	int failures = 0, total_checks = 0;
	input_terminal_command_decoder #(.FREQ_W(16)) i_dut (.clk, .rst, .gp_terminal,
		.fwd_terminal, .rev_terminal, .input1_assignment, .input2_assignment,
		.input3_assignment, .fwd_pin_assignment, .rev_pin_assignment, .primary_freq_source,
		.secondary_freq_source, .preset_frequency_table, .accel_time_first, .decel_time_first,
		.accel_time_second, .decel_time_second, .fault_event, .cmd_reg, .speed_index_reg,
		.freq_ref_reg, .accel_time_reg, .decel_time_reg, .run_fwd_reg, .run_rev_reg,
		.drive_enable_reg, .fault_alarm_output, .alarm_display_reg, .trip_hold_reg);
	term_driver i_drv (.clk, .slow, .want, .gp_terminal, .fwd_terminal, .rev_terminal);
	initial
		forever #12.5 clk = ~clk;
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic assign_all(logic [10:0] a1, a2, a3, af, ar);
		input1_assignment = a1;
		input2_assignment = a2;
		input3_assignment = a3;
		fwd_pin_assignment = af;
		rev_pin_assignment = ar;
	endtask
	// covers sync and decode latency with margin for slow relays
	task automatic step(logic [4:0] w);
		want = w;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic t_codes;
		int code[20] = '{0, 1, 2, 3, 4, 6, 7, 8, 10, 11, 12, 13, 17, 18, 19, 20, 21, 24, 33, 34};
		int pos[20] = '{19, 20, 21, 22, 18, 17, 16, 15, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2};
		for (int i = 0; i < 20; i++)
		begin
			assign_all(11'(code[i]), 11'h022, 11'h022, 11'h062, 11'h063);
			step(5'h01);
			chk("command", 32'h1 << pos[i], cmd_reg);
			assign_all(11'(code[i] + 1000), 11'h022, 11'h022, 11'h062, 11'h063);
			step(5'h00);
			chk("low command", code[i] == 13 ? 0 : 32'h1 << pos[i], cmd_reg);
		end
		$display("codes done");
	endtask
	task automatic t_preset;
		slow = 1'b1;
		assign_all(11'h000, 11'h001, 11'h002, 11'h003, 11'h00b);
		for (int i = 0; i < 16; i++)
		begin
			step(5'(i));
			chk("speed index", i, speed_index_reg);
			chk("frequency", i == 0 ? 16'h0aaa : 16'h0100 + i, freq_ref_reg);
		end
		step(5'h10);
		chk("frequency", 16'h0bbb, freq_ref_reg);
		slow = 1'b0;
		$display("preset done");
	endtask
	task automatic t_ramp;
		assign_all(11'h004, 11'h022, 11'h022, 11'h062, 11'h063);
		step(5'h01);
		chk("accel", 16'h0033, accel_time_reg);
		chk("decel", 16'h0044, decel_time_reg);
		step(5'h00);
		chk("accel", 16'h0011, accel_time_reg);
		assign_all(11'h022, 11'h022, 11'h022, 11'h062, 11'h063);
		step(5'h01);
		chk("decel", 16'h0022, decel_time_reg);
		$display("ramp done");
	endtask
	task automatic t_wire;
		assign_all(11'h006, 11'h022, 11'h022, 11'h062, 11'h063);
		step(5'h01);
		step(5'h09);
		step(5'h11);
		chk("run fwd", 1, run_fwd_reg);
		chk("run rev", 0, run_rev_reg);
		step(5'h10);
		chk("run fwd", 0, run_fwd_reg);
		assign_all(11'h007, 11'h022, 11'h022, 11'h062, 11'h063);
		step(5'h10);
		chk("run rev", 1, run_rev_reg);
		chk("drive", 1, drive_enable_reg);
		step(5'h11);
		chk("drive", 0, drive_enable_reg);
		chk("alarm", 0, fault_alarm_output);
		step(5'h00);
		chk("run rev", 0, run_rev_reg);
		$display("wire done");
	endtask
	task automatic t_alarm;
		assign_all(11'h009, 11'h008, 11'h022, 11'h062, 11'h063);
		step(5'h00);
		chk("trip", 1, cmd_reg.external_trip_cmd);
		step(5'h01);
		chk("alarm", 1, fault_alarm_output);
		step(5'h03); // press kept short to bound run time; one step of 8 clocks is enough here
		chk("alarm", 0, fault_alarm_output);
		chk("display", 1, alarm_display_reg);
		chk("held", 1, trip_hold_reg);
		step(5'h01);
		chk("display", 0, alarm_display_reg);
		chk("held", 0, trip_hold_reg);
		// park the trip input on a harmless code before flipping its polarity
		assign_all(11'h022, 11'h011, 11'h062, 11'h011, 11'h062);
		step(5'h00);
		assign_all(11'h3f1, 11'h011, 11'h062, 11'h011, 11'h062);
		step(5'h00);
		chk("alarm", 0, fault_alarm_output);
		step(5'h06);
		chk("or", 32'h200, cmd_reg);
		step(5'h01);
		chk("alarm", 1, fault_alarm_output);
		$display("alarm done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#100us;
		failures++;
		report_and_stop;
	end
	initial
	begin
		assign_all(11'h022, 11'h022, 11'h022, 11'h062, 11'h063);
		for (int k = 0; k < 15; k++)
			preset_frequency_table[k*16 +: 16] = 16'h0101 + 16'(k);
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		t_codes;
		t_preset;
		t_ramp;
		t_wire;
		t_alarm;
		report_and_stop;
	end
endmodule
bind input_terminal_command_decoder term_decode_properties #(.FREQ_W(FREQ_W)) i_props (.clk,
	.rst, .preset_frequency_table, .accel_time_second, .fault_event, .cmd_reg, .speed_index_reg,
	.freq_ref_reg, .accel_time_reg, .run_fwd_reg, .run_rev_reg, .drive_enable_reg,
	.fault_alarm_output, .alarm_display_reg, .trip_hold_reg);
